/* core/wdsc_pkg.sv */
// Package with register map, field layout and timing constants for the watchdog block
package wdsc_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] ADDR_WDT_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_OPTION = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0c;

    // Reset values
    localparam logic [7:0] WDT_CONTROL_RESET = 8'h08;
    localparam logic [7:0] OPTION_RESET = 8'hff;

    // Field positions
    localparam int ENABLE_BIT = 0;
    localparam int PERIOD_LSB = 1;
    localparam int ASSIGN_BIT = 3;
    localparam int STATUS_EXPIRY_BIT = 0;
    localparam int STATUS_POWERDOWN_BIT = 1;
    localparam int STATUS_ASLEEP_BIT = 2;
    localparam int STATUS_STARTUP_BIT = 3;

    // Highest legal period code, prescale 1:32 shifted left by the code
    localparam logic [3:0] PERIOD_MAX = 4'hb;
    localparam int PERIOD_BASE_SHIFT = 5;

    // Start-up delay in oscillator periods
    localparam int STARTUP_PERIODS = 1024;

    // Low-frequency oscillator in kHz and clock rate in kHz
    localparam int LFOSC_KHZ = 31;
    localparam int CLK_KHZ = 250000;
    localparam int LFOSC_DIV = CLK_KHZ / LFOSC_KHZ;

    // Sleep state machine
    typedef enum logic [1:0] {
        WDSC_AWAKE = 2'b00,
        WDSC_ASLEEP = 2'b01,
        WDSC_STARTUP = 2'b10
    } wdsc_mode_e;

    // System clock kind selected by configuration
    typedef enum logic [1:0] {
        WDSC_CLK_RC = 2'b00,
        WDSC_CLK_EXT = 2'b01,
        WDSC_CLK_CRYSTAL = 2'b10,
        WDSC_CLK_TIMER_XTAL = 2'b11
    } wdsc_clk_e;

    // Core event inputs
    typedef struct packed {
        logic sleepInstr;
        logic watchdogClearInstruction;
        logic oscFailure;
        logic irqEnabledPending;
        logic globalIrqEnable;
        logic externalResetPin;
        logic powerUp;
    } wdsc_events_s;

    // APB slave response
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } wdsc_apb_rsp_s;

endpackage

/* core/wdsc_watchdog.sv */
// Watchdog timer with sleep and wake-up control behind an APB slave
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// R01 - Counter from low-frequency oscillator, 16-bit prescaler
// R02 - Optional shared 8-bit prescaler, assign and ratio
// R03 - Period code: 1:32 doubling to 1:65536
// R04 - Reset control value 0x08, bits 7-5 zero
// R05 - Force bit runs watchdog regardless of enable
// R06 - Without force, software enable bit gates watchdog
// R07 - Held cleared during oscillator start-up count
// R08 - Cleared on disable, clear, oscillator fail, wake
// R09 - Crystal wake: cleared until 1024 periods elapse
// R10 - Sleep: clear watchdog, powerdown low, expiry set
// R11 - Timeout reset stays internal, pin untouched
// R12 - Wake on reset pin, watchdog, enabled interrupt
// R13 - Powerdown set on power-up; expiry cleared on watchdog wake
// R14 - Sleep prefetches next instruction
// R15 - Interrupt wake; vector only when global enable set
// R16 - Every wake-up clears the watchdog
// R17 - Pending interrupt with global enable clear makes sleep a no-operation
// R18 - Interrupt during sleep: finish sleep, then wake
// R19 - Software clears watchdog before sleep, checks flag
// R20 - Awake expiry resets device; asleep expiry wakes
module wdsc_watchdog #(
    parameter int LFOSC_DIV = wdsc_pkg::LFOSC_DIV,
    parameter int STARTUP_PERIODS = wdsc_pkg::STARTUP_PERIODS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration and core events
    input wire logic configWatchdogForce,
    input wire wdsc_pkg::wdsc_clk_e systemClockKind,
    input wire wdsc_pkg::wdsc_events_s events,
    // Device outputs
    output logic deviceReset,
    output logic wakeResume,
    output logic takeVector,
    output logic prefetchNext,
    output logic oscDriverOff,
    output logic holdPorts,
    output logic expiryFlag,
    output logic powerdownFlag
);

    // All state of the block
    typedef struct packed {
        logic [7:0] wdtControl;
        logic [7:0] optionReg;
        logic [15:0] lfDiv;
        logic lfTick;
        logic [7:0] shared;
        logic [15:0] prescale;
        logic [15:0] startup;
        wdsc_pkg::wdsc_mode_e mode;
        logic expiry;
        logic powerdown;
        logic [31:0] rdata;
        logic ready;
        logic slvErr;
        logic devReset;
        logic wake;
        logic vector;
        logic prefetch;
        logic sleepOut;
    } wdsc_state_s;

    wdsc_state_s st;
    wdsc_state_s next_st;

    // Prescale length for a period code, reserved codes act as the longest
    function automatic logic [15:0] periodMask(input logic [3:0] code);
        logic [3:0] c;
        c = (code > wdsc_pkg::PERIOD_MAX) ? wdsc_pkg::PERIOD_MAX : code;
        // Five-bit shift amount, code 1011 plus base reaches 16
        periodMask = 16'((32'h1 << (5'(c) + 5'(wdsc_pkg::PERIOD_BASE_SHIFT))) - 32'h1);
    endfunction

    // Shared prescaler length for the ratio bits
    function automatic logic [7:0] ratioMask(input logic [2:0] r);
        ratioMask = 8'((16'h2 << r) - 16'h1);
    endfunction

    logic running;
    logic periodDone;
    logic sharedDone;
    logic expired;
    logic sleepTakes;
    logic setup;
    logic access;

    // Enable, expiry and bus decode
    always_comb begin
        running = configWatchdogForce || st.wdtControl[wdsc_pkg::ENABLE_BIT]; // R05 R06
        periodDone = ((st.prescale & periodMask(st.wdtControl[4:1])) ==
            periodMask(st.wdtControl[4:1])); // R03
        sharedDone = !st.optionReg[wdsc_pkg::ASSIGN_BIT] ||
            ((st.shared & ratioMask(st.optionReg[2:0])) == ratioMask(st.optionReg[2:0])); // R02
        expired = running && st.lfTick && periodDone && sharedDone &&
            (st.mode != wdsc_pkg::WDSC_STARTUP);
        sleepTakes = events.sleepInstr && (st.mode == wdsc_pkg::WDSC_AWAKE) &&
            !(events.irqEnabledPending && !events.globalIrqEnable); // R17
        setup = psel && !penable;
        access = psel && penable;
    end

    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.ready = 1'b0;
        next_st.slvErr = 1'b0;
        next_st.devReset = 1'b0;
        next_st.wake = 1'b0;
        next_st.vector = 1'b0;
        next_st.prefetch = 1'b0;

        // Low-frequency tick derived from the system clock
        if (st.lfDiv == 16'(LFOSC_DIV - 1)) begin
            next_st.lfDiv = 16'h0000;
            next_st.lfTick = 1'b1; // R01
        end else begin
            next_st.lfDiv = st.lfDiv + 16'h0001;
            next_st.lfTick = 1'b0;
        end

        // Prescaler chain advances on each oscillator tick
        if (running && st.lfTick && st.mode != wdsc_pkg::WDSC_STARTUP) begin
            if (!st.optionReg[wdsc_pkg::ASSIGN_BIT] || sharedDone) begin
                next_st.prescale = st.prescale + 16'h0001; // R01
            end
            if (st.optionReg[wdsc_pkg::ASSIGN_BIT]) begin
                next_st.shared = sharedDone ? 8'h00 : st.shared + 8'h01; // R02
            end
        end

        // Clear conditions
        if (!running || events.watchdogClearInstruction || events.oscFailure ||
            expired) begin
            next_st.prescale = 16'h0000; // R08
            next_st.shared = 8'h00;
        end

        // Sleep and wake-up sequencing
        unique case (st.mode)
            wdsc_pkg::WDSC_AWAKE: begin
                if (expired) begin
                    next_st.devReset = 1'b1; // R20 R11
                    next_st.expiry = 1'b0;
                end else if (sleepTakes) begin
                    next_st.prescale = 16'h0000; // R10
                    next_st.shared = 8'h00;
                    next_st.powerdown = 1'b0; // R13
                    next_st.expiry = 1'b1;
                    next_st.prefetch = 1'b1; // R14
                    next_st.mode = wdsc_pkg::WDSC_ASLEEP;
                end
            end
            wdsc_pkg::WDSC_ASLEEP: begin
                if (expired || events.irqEnabledPending) begin // R12 R18
                    if (expired) begin
                        next_st.expiry = 1'b0; // R13 R20
                    end
                    next_st.prescale = 16'h0000; // R16
                    next_st.shared = 8'h00;
                    if (systemClockKind == wdsc_pkg::WDSC_CLK_CRYSTAL) begin
                        next_st.startup = 16'h0000; // R09
                        next_st.mode = wdsc_pkg::WDSC_STARTUP;
                    end else begin
                        next_st.wake = 1'b1; // R08
                        next_st.vector = events.irqEnabledPending &&
                            events.globalIrqEnable; // R15
                        next_st.mode = wdsc_pkg::WDSC_AWAKE;
                    end
                end
            end
            wdsc_pkg::WDSC_STARTUP: begin
                next_st.prescale = 16'h0000; // R07 R09
                next_st.shared = 8'h00;
                if (st.startup == 16'(STARTUP_PERIODS - 1)) begin
                    next_st.wake = 1'b1;
                    next_st.vector = events.irqEnabledPending && events.globalIrqEnable;
                    next_st.mode = wdsc_pkg::WDSC_AWAKE;
                end else begin
                    next_st.startup = st.startup + 16'h0001;
                end
            end
            default: begin
                next_st.mode = wdsc_pkg::WDSC_AWAKE;
            end
        endcase

        // APB access phase, ready one cycle after access starts (one wait state)
        if (access && !st.ready) begin
            next_st.ready = 1'b1;
            next_st.rdata = 32'h0000_0000;
            unique case (paddr)
                wdsc_pkg::ADDR_WDT_CONTROL: begin
                    if (pwrite) begin
                        next_st.wdtControl = {3'b000, pwdata[4:0]}; // R04
                    end
                    next_st.rdata = {24'h000000, st.wdtControl};
                end
                wdsc_pkg::ADDR_OPTION: begin
                    if (pwrite) begin
                        next_st.optionReg = pwdata[7:0];
                    end
                    next_st.rdata = {24'h000000, st.optionReg};
                end
                wdsc_pkg::ADDR_STATUS: begin
                    next_st.rdata = {28'h0000000,
                        st.mode == wdsc_pkg::WDSC_STARTUP,
                        st.mode == wdsc_pkg::WDSC_ASLEEP,
                        st.powerdown, st.expiry};
                end
                wdsc_pkg::ADDR_COUNT: begin
                    next_st.rdata = {16'h0000, st.prescale};
                end
                default: begin
                    next_st.slvErr = 1'b1;
                end
            endcase
        end
        if (setup) begin
            next_st.ready = 1'b0;
        end

        // External reset pin: reloads control registers, clears prescalers, keeps both flags, wakes from sleep
        if (events.externalResetPin) begin // R12
            next_st.wdtControl = wdsc_pkg::WDT_CONTROL_RESET;
            next_st.optionReg = wdsc_pkg::OPTION_RESET;
            next_st.prescale = 16'h0000;
            next_st.shared = 8'h00;
            next_st.mode = wdsc_pkg::WDSC_AWAKE;
        end
        // Power-up sets both flags
        if (events.powerUp) begin
            next_st.powerdown = 1'b1; // R13
            next_st.expiry = 1'b1;
        end
        // Watchdog reset reloads control registers too
        if (st.devReset) begin
            next_st.wdtControl = wdsc_pkg::WDT_CONTROL_RESET; // R04
            next_st.optionReg = wdsc_pkg::OPTION_RESET;
        end
        // Registered sleep level for the oscillator and port outputs
        next_st.sleepOut = (next_st.mode != wdsc_pkg::WDSC_AWAKE); // R10
    end

    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= '0;
            st.wdtControl <= wdsc_pkg::WDT_CONTROL_RESET; // R04
            st.optionReg <= wdsc_pkg::OPTION_RESET;
            st.mode <= wdsc_pkg::WDSC_AWAKE;
            st.powerdown <= 1'b1;
            st.expiry <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    always_comb begin
        prdata = st.rdata;
        pready = st.ready;
        pslverr = st.slvErr;
        deviceReset = st.devReset;
        wakeResume = st.wake;
        takeVector = st.vector;
        prefetchNext = st.prefetch;
        oscDriverOff = st.sleepOut; // R10
        holdPorts = st.sleepOut;
        expiryFlag = st.expiry;
        powerdownFlag = st.powerdown;
    end

endmodule

/* sim/wdsc_watchdog_assertions.sv */
// Port checker for the watchdog and sleep control block
`timescale 1ns/1ps
module wdsc_watchdog_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bus handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Events and device outputs
    input wire wdsc_pkg::wdsc_events_s events,
    input wire logic deviceReset,
    input wire logic wakeResume,
    input wire logic takeVector,
    input wire logic prefetchNext,
    input wire logic oscDriverOff,
    input wire logic holdPorts,
    input wire logic expiryFlag,
    input wire logic powerdownFlag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Bus answer and its one-cycle pulse
    property p_answer;
        psel && penable && !pready |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after access");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    // Sleep entry effects
    property p_prefetch;
        prefetchNext |-> $past(events.sleepInstr);
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("prefetch without sleep");
    property p_sleep_flags;
        prefetchNext |-> expiryFlag && !powerdownFlag && oscDriverOff && holdPorts;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep entry wrong");
    property p_noop;
        events.sleepInstr && events.irqEnabledPending && !events.globalIrqEnable
            && !oscDriverOff && !events.powerUp && !events.externalResetPin
            |=> !prefetchNext && $stable(powerdownFlag) && !oscDriverOff;
    endproperty
    a_noop: assert property (p_noop) else $error("pending sleep not skipped");
    // Expiry and wake outputs
    property p_reset_awake;
        deviceReset |-> !expiryFlag && $past(!holdPorts);
    endproperty
    a_reset_awake: assert property (p_reset_awake) else $error("bad expiry reset");
    property p_vector;
        takeVector |-> wakeResume;
    endproperty
    a_vector: assert property (p_vector) else $error("vector without wake");
    property p_wake;
        wakeResume |-> $past(oscDriverOff);
    endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
endmodule

bind wdsc_watchdog wdsc_watchdog_chk u_chk (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
    .events(events), .deviceReset(deviceReset), .wakeResume(wakeResume),
    .takeVector(takeVector), .prefetchNext(prefetchNext), .oscDriverOff(oscDriverOff),
    .holdPorts(holdPorts), .expiryFlag(expiryFlag), .powerdownFlag(powerdownFlag)
);

/* sim/wdsc_testbench.sv */
// Self-checking bench for the watchdog and sleep control block
`timescale 1ns/1ps
module testbench;
    logic clk = 0;
    logic reset_n = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, v;
    logic pready, pslverr, er, cfgForce = 0;
    wdsc_pkg::wdsc_clk_e clkKind = wdsc_pkg::WDSC_CLK_RC;
    wdsc_pkg::wdsc_events_s ev = '0;
    logic devRst, wake, vec, pref, oscOff, hold, toF, pdF, vecSeen;
    logic [31:0] seed = 32'h96b3;
    int nMismatch = 0;
    int checksDone = 0;
    int waitCnt, nRst = 0;
    int mTo = 1;
    int mPd = 1;

    // Clock and reset-count watch
    always #2 clk = ~clk;
    always @(posedge clk) if (devRst === 1'b1) nRst++;

    wdsc_watchdog #(.LFOSC_DIV(4), .STARTUP_PERIODS(8)) dut (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .configWatchdogForce(cfgForce), .systemClockKind(clkKind), .events(ev),
        .deviceReset(devRst), .wakeResume(wake), .takeVector(vec), .prefetchNext(pref),
        .oscDriverOff(oscOff), .holdPorts(hold), .expiryFlag(toF), .powerdownFlag(pdF)
    );

    // Xorshift source
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Value compare
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (g !== e) begin
            nMismatch++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Counts and verdict
    task summarize();
        $display("checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One bus transfer, held until ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(negedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            chk("bus wait", 1, 0);
            summarize();
        end
        rd = prdata;
        er = pslverr;
        @(posedge clk);
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask

    // Bounded wait for reset (s=0) or wake (s=1)
    task waitOn(input int s, input int lim);
        for (waitCnt = 0; waitCnt < lim; waitCnt++) begin
            @(negedge clk);
            if ((s == 0 ? devRst : wake) === 1'b1) break;
        end
        vecSeen = vec;
        if (waitCnt == lim) begin
            chk("wait bound", 1, 0);
            summarize();
        end
        @(posedge clk);
    endtask

    // Sleep instruction and its entry effects
    task doSleep(input logic taken);
        ev.sleepInstr <= 1;
        @(posedge clk);
        ev.sleepInstr <= 0;
        @(negedge clk);
        if (taken) begin
            mTo = 1;
            mPd = 0;
        end
        chk("prefetch", taken, pref);
        chk("expiry", mTo, toF);
        chk("powerdown", mPd, pdF);
        chk("oscOff", taken, oscOff);
        chk("hold", taken, hold);
        @(posedge clk);
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1;
        @(posedge clk);
        apb(0, wdsc_pkg::ADDR_WDT_CONTROL, 0);
        chk("control", 8'h08, rd[7:0]);
        apb(0, wdsc_pkg::ADDR_OPTION, 0);
        chk("option", 8'hff, rd[7:0]);
        apb(0, wdsc_pkg::ADDR_STATUS, 0);
        chk("status", 4'h3, rd[3:0]);
        apb(1, 8'h10, 32'h1);
        chk("slverr", 1, er);
        repeat (4) begin
            v = rnd();
            v[4:1] = v[4:1] % 12;
            v[0] = 0;
            apb(1, wdsc_pkg::ADDR_WDT_CONTROL, v);
            apb(0, wdsc_pkg::ADDR_WDT_CONTROL, 0);
            chk("control", {3'b000, v[4:0]}, rd[7:0]);
            apb(1, wdsc_pkg::ADDR_OPTION, v);
            apb(0, wdsc_pkg::ADDR_OPTION, 0);
            chk("option", v[7:0], rd[7:0]);
        end
        apb(1, wdsc_pkg::ADDR_OPTION, 0);
        apb(1, wdsc_pkg::ADDR_WDT_CONTROL, 0);
        ev.irqEnabledPending <= 1;
        @(posedge clk);
        doSleep(0);
        ev.irqEnabledPending <= 0;
        ev.globalIrqEnable <= 1;
        clkKind <= wdsc_pkg::WDSC_CLK_CRYSTAL;
        @(posedge clk);
        doSleep(1);
        ev.irqEnabledPending <= 1;
        waitOn(1, 60);
        chk("vector", 1, vecSeen);
        chk("startup", 1, waitCnt >= 8);
        ev.irqEnabledPending <= 0;
        ev.globalIrqEnable <= 0;
        clkKind <= wdsc_pkg::WDSC_CLK_RC;
        apb(0, wdsc_pkg::ADDR_STATUS, 0);
        chk("status", 4'h1, rd[3:0]);
        apb(1, wdsc_pkg::ADDR_WDT_CONTROL, 32'h1);
        ev.watchdogClearInstruction <= 1;
        @(posedge clk);
        ev.watchdogClearInstruction <= 0;
        doSleep(1);
        waitOn(1, 3000);
        chk("vector", 0, vecSeen);
        apb(0, wdsc_pkg::ADDR_STATUS, 0);
        chk("status", 4'h0, rd[3:0]);
        for (int k = 0; k < 40; k++) begin
            ev.watchdogClearInstruction <= k[0];
            ev.oscFailure <= !k[0];
            @(posedge clk);
            ev.watchdogClearInstruction <= 0;
            ev.oscFailure <= 0;
            repeat (15) @(posedge clk);
        end
        apb(1, wdsc_pkg::ADDR_WDT_CONTROL, 0);
        repeat (600) @(posedge clk);
        chk("no reset", 0, nRst);
        cfgForce <= 1;
        waitOn(0, 3000);
        apb(0, wdsc_pkg::ADDR_WDT_CONTROL, 0);
        chk("control", 8'h08, rd[7:0]);
        apb(0, wdsc_pkg::ADDR_STATUS, 0);
        chk("status", 4'h0, rd[3:0]);
        ev.powerUp <= 1;
        @(posedge clk);
        ev.powerUp <= 0;
        apb(0, wdsc_pkg::ADDR_STATUS, 0);
        chk("status", 4'h3, rd[3:0]);
        // Shared prescaler 1:2 doubles the 1:32 period to 64 ticks
        apb(1, wdsc_pkg::ADDR_OPTION, 32'h08);
        apb(1, wdsc_pkg::ADDR_WDT_CONTROL, 32'h01);
        ev.watchdogClearInstruction <= 1;
        @(posedge clk);
        ev.watchdogClearInstruction <= 0;
        waitOn(0, 3000);
        chk("shared period", 1, waitCnt >= 240 && waitCnt <= 272);
        summarize();
    end

    // Run bound
    initial begin
        repeat (100000) @(posedge clk);
        chk("run bound", 1, 0);
        summarize();
    end
endmodule
